/* verilog/btte_pkg.sv */
// btte_pkg: constants, carriers and state layout of the trigger-event matchers
package btte_pkg;

    // ************************************************************
    // register map
    // ************************************************************
    localparam int BTTE_NUM = 8;  // number of matchers
    localparam logic [31:0] TMC_OFF_0 = 32'h10020a20;
    localparam logic [31:0] TMC_OFF_1 = 32'h10020a28;
    localparam logic [31:0] TMC_OFF_2 = 32'h10020a30;
    localparam logic [31:0] TMC_OFF_3 = 32'h10020a38;
    localparam logic [31:0] TMC_OFF_4 = 32'h10020a60;
    localparam logic [31:0] TMC_OFF_5 = 32'h10020a68;
    localparam logic [31:0] TMC_OFF_6 = 32'h10020a70;
    localparam logic [31:0] TMC_OFF_7 = 32'h10020a78;
    localparam logic [7:0][31:0] TMC_OFF = {TMC_OFF_7, TMC_OFF_6, TMC_OFF_5,
        TMC_OFF_4, TMC_OFF_3, TMC_OFF_2, TMC_OFF_1, TMC_OFF_0};

    // ************************************************************
    // control field positions
    // ************************************************************
    localparam int F_TRAP_LO = 0;   // trap select 3:0
    localparam int F_REQ_EN = 4;    // requester_compare_enable
    localparam int F_DSRC_EN = 5;   // data_source_compare_enable
    localparam int F_RESP_EN = 6;   // responder_compare_enable
    localparam int F_INT_EN = 7;    // interrupt source enable
    localparam int F_RSVD = 8;      // reserved
    localparam int F_DBG_EN = 9;    // external line enable
    localparam int F_WR_EN = 10;    // write-class qualifier
    localparam int F_RD_EN = 11;    // read-class qualifier
    localparam int F_REQ_LO = 12;   // requester_code 15:12
    localparam int F_RESP_LO = 16;  // responder_code 19:16
    localparam int F_DSRC_LO = 20;  // data_source_code 23:20
    localparam int F_CNT_LO = 24;   // count 31:24
    localparam logic [23:0] CFG_WMASK = 24'hfffeff;  // bit 8 not stored
    localparam logic [23:0] CFG_RST = 24'h000000;
    localparam logic [7:0] CNT_RST = 8'h00;

    // bus command codes on the address phase
    typedef enum logic [2:0] {
        BTTE_CMD_IDLE = 3'h0,
        BTTE_CMD_SHARED_READ = 3'h1,     // shared_read_command
        BTTE_CMD_EXCLUSIVE_READ = 3'h2,  // exclusive_read_command
        BTTE_CMD_WRITE = 3'h3,
        BTTE_CMD_WRITE_INV = 3'h4,
        BTTE_CMD_INVALIDATE = 3'h5
    } btte_cmd_e;

    // address-phase carrier
    typedef struct packed {
        logic valid;
        btte_cmd_e cmd;
        logic [3:0] req_id;    // requester of the transaction
        logic [3:0] trap_hit;  // range hits of the four address traps
    } btte_abus_s;

    // data-phase carrier
    typedef struct packed {
        logic valid;
        logic [3:0] data_id;  // upper nibble of the transaction id
        logic [3:0] resp_id;  // responder that supplies the data
    } btte_dbus_s;

    // whole state of the block
    typedef struct packed {
        logic [7:0][23:0] cfg;   // stored control fields
        logic [7:0][7:0] init;   // reload values
        logic [7:0][7:0] cnt;    // live counters
        logic [7:0] evt;         // event pulses
        logic dbg_s1;
        logic dbg_s2;
        logic dbg_arm;
        logic int_arm;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } btte_state_s;

endpackage : btte_pkg

/* verilog/btte_trigger_events.sv */
// btte_trigger_events: eight trigger-event matchers with an apb register port
//
// Decided for this implementation: register access over APB.
module btte_trigger_events (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire btte_pkg::btte_abus_s abus,
    input wire btte_pkg::btte_dbus_s dbus,
    input wire logic [1:0] int_trace,
    input wire logic dbg_line_n,
    output logic [7:0] event_pulse
);

    // ************************************************************
    // state and next state
    // ************************************************************
    btte_pkg::btte_state_s st_r;   // registered state
    btte_pkg::btte_state_s st_nxt; // next state

    logic [7:0] sel_hit;   // register decode per matcher
    logic any_hit;         // any mapped register addressed
    logic acc_done;        // access phase completes this edge
    logic acc_start;       // first access cycle, read data sampled
    logic [7:0] wr_sel;    // write strobe per matcher
    logic [7:0] addr_hit;  // address-phase condition per matcher
    logic [7:0] data_hit;  // data-phase condition per matcher
    logic [7:0] trig;      // overall condition per matcher
    logic rd_cls;          // read-class command on the bus
    logic wr_cls;          // write-class command on the bus
    logic int_any;         // either mapper output asserted
    logic int_fire;        // interrupt rising edge
    logic dbg_fire;        // debug line falling edge

    // ************************************************************
    // apb decode
    // ************************************************************

    // completes on the edge where our registered ready is seen
    assign acc_done = psel & penable & st_r.pready;
    // ready comes one cycle into the access phase
    assign acc_start = psel & penable & ~st_r.pready;
    assign any_hit = |sel_hit;

    // full 32-bit compare against each printed offset
    genvar g;
    generate
        for (g = 0; g < btte_pkg::BTTE_NUM; g++) begin : g_dec
            assign sel_hit[g] = (paddr == btte_pkg::TMC_OFF[g]);
            assign wr_sel[g] = acc_done & pwrite & sel_hit[g];
        end
    endgenerate

    // ************************************************************
    // command classes
    // ************************************************************

    // shared and exclusive reads form the read class
    assign rd_cls = abus.valid & ((abus.cmd == btte_pkg::BTTE_CMD_SHARED_READ) |
        (abus.cmd == btte_pkg::BTTE_CMD_EXCLUSIVE_READ));
    // write, write-invalidate and invalidate form the write class
    assign wr_cls = abus.valid & ((abus.cmd == btte_pkg::BTTE_CMD_WRITE) |
        (abus.cmd == btte_pkg::BTTE_CMD_WRITE_INV) |
        (abus.cmd == btte_pkg::BTTE_CMD_INVALIDATE));

    // ************************************************************
    // shared edge detectors
    // ************************************************************

    // mapper outputs are on this clock, so no synchroniser
    assign int_any = |int_trace;
    // arm holds last cycle's "both clear"; no record of which mapper
    assign int_fire = int_any & st_r.int_arm;
    // arm holds last synchronised high level of the line
    assign dbg_fire = ~st_r.dbg_s2 & st_r.dbg_arm;

    // ************************************************************
    // per-matcher conditions
    // ************************************************************
    generate
        for (g = 0; g < btte_pkg::BTTE_NUM; g++) begin : g_match
            logic [23:0] c;       // this matcher's control fields
            logic req_ok;         // requester check
            logic trap_ok;        // trap check
            logic cmd_ok;         // read/write check
            logic dsrc_ok;        // data-source check
            logic resp_ok;        // responder check
            assign c = st_r.cfg[g];

            // requester code compared only when enabled
            assign req_ok = ~c[btte_pkg::F_REQ_EN] |
                (abus.req_id == c[btte_pkg::F_REQ_LO +: 4]);
            // no selects: address ignored; else any selected trap hit.
            // trap hits arrive raw, the trap's own counter never gates them
            assign trap_ok = (c[btte_pkg::F_TRAP_LO +: 4] == 4'h0) |
                (|(c[btte_pkg::F_TRAP_LO +: 4] & abus.trap_hit));
            // both qualifiers clear leaves cmd_ok low for good
            assign cmd_ok = (c[btte_pkg::F_RD_EN] & rd_cls) |
                (c[btte_pkg::F_WR_EN] & wr_cls);
            // all three must hold together
            assign addr_hit[g] = req_ok & trap_ok & cmd_ok;

            // data id is the upper transaction-id nibble from the carrier
            assign dsrc_ok = (dbus.data_id == c[btte_pkg::F_DSRC_LO +: 4]);
            assign resp_ok = (dbus.resp_id == c[btte_pkg::F_RESP_LO +: 4]);
            // at least one enable set; every set enable must match
            assign data_hit[g] = dbus.valid &
                (c[btte_pkg::F_DSRC_EN] | c[btte_pkg::F_RESP_EN]) &
                (~c[btte_pkg::F_DSRC_EN] | dsrc_ok) &
                (~c[btte_pkg::F_RESP_EN] | resp_ok);

            // any source raises the condition
            assign trig[g] = addr_hit[g] | data_hit[g] |
                (c[btte_pkg::F_INT_EN] & int_fire) |
                (c[btte_pkg::F_DBG_EN] & dbg_fire);
        end
    endgenerate

    // ************************************************************
    // next-state logic
    // ************************************************************

    // one pass fills the whole next state
    always_comb begin
        st_nxt = st_r;
        // pulses last a single clock unless retriggered
        st_nxt.evt = 8'h00;
        // two flops on the asynchronous debug line
        st_nxt.dbg_s1 = dbg_line_n;
        st_nxt.dbg_s2 = st_r.dbg_s1;
        // rearm only after a high level was seen
        st_nxt.dbg_arm = st_r.dbg_s2;
        // rearm only once both mappers are clear
        st_nxt.int_arm = ~int_any;
        // ready one access cycle late, then drop
        st_nxt.pready = acc_start;
        st_nxt.pslverr = acc_start & ~any_hit;

        // read data sampled with the rising ready
        if (acc_start) begin
            st_nxt.prdata = 32'h00000000;
            for (int i = 0; i < btte_pkg::BTTE_NUM; i++) begin
                if (sel_hit[i]) begin
                    // live count on top, bit 8 kept zero
                    st_nxt.prdata = {st_r.cnt[i], st_r.cfg[i]};
                end
            end
        end

        for (int i = 0; i < btte_pkg::BTTE_NUM; i++) begin
            if (wr_sel[i]) begin
                // software write wins over a match in the same cycle
                st_nxt.cfg[i] = pwdata[23:0] & btte_pkg::CFG_WMASK;
                st_nxt.init[i] = pwdata[btte_pkg::F_CNT_LO +: 8];
                // counter restarts from the new value
                st_nxt.cnt[i] = pwdata[btte_pkg::F_CNT_LO +: 8];
            end else if (trig[i]) begin
                if (st_r.cnt[i] != 8'h00) begin
                    // swallow this occurrence
                    st_nxt.cnt[i] = st_r.cnt[i] - 8'h01;
                end else begin
                    // signal and reload
                    st_nxt.evt[i] = 1'b1;
                    st_nxt.cnt[i] = st_r.init[i];
                end
            end
        end
    end

    // ************************************************************
    // state register
    // ************************************************************

    // every field clears to zero; all matchers start idle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_r.cfg <= {8{btte_pkg::CFG_RST}};
            st_r.init <= {8{btte_pkg::CNT_RST}};
            st_r.cnt <= {8{btte_pkg::CNT_RST}};
            st_r.evt <= 8'h00;
            st_r.dbg_s1 <= 1'b0;
            st_r.dbg_s2 <= 1'b0;
            st_r.dbg_arm <= 1'b0;
            st_r.int_arm <= 1'b0;
            st_r.pready <= 1'b0;
            st_r.pslverr <= 1'b0;
            st_r.prdata <= 32'h00000000;
        end else begin
            st_r <= st_nxt;
        end
    end

    // ************************************************************
    // outputs
    // ************************************************************
    assign prdata = st_r.prdata;
    assign pready = st_r.pready;
    assign pslverr = st_r.pslverr;
    assign event_pulse = st_r.evt;

    // ************************************************************
    // checks
    // ************************************************************
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    // nonzero count drops by one and stays quiet
    cnt_dec_a: assert property (
        trig[0] && !wr_sel[0] && st_r.cnt[0] != 8'h00 |=>
        st_r.cnt[0] == $past(st_r.cnt[0]) - 8'h01 && !event_pulse[0])
        else $error("count did not decrement");

    // zero count fires and reloads
    fire_reload_a: assert property (
        trig[0] && !wr_sel[0] && st_r.cnt[0] == 8'h00 |=>
        event_pulse[0] && st_r.cnt[0] == $past(st_r.init[0]))
        else $error("event or reload missing");

    // events only follow a true condition
    evt_cause_a: assert property (
        event_pulse[3] |-> $past(trig[3]) && $past(st_r.cnt[3]) == 8'h00)
        else $error("event without cause");

    // reserved bit never stored
    rsvd_zero_a: assert property (
        st_r.cfg[5][btte_pkg::F_RSVD] == 1'b0)
        else $error("reserved bit set");

    // read returns live count taken at sampling
    read_live_a: assert property (
        pready && !pwrite && paddr == btte_pkg::TMC_OFF_0 |->
        prdata[31:24] == $past(st_r.cnt[0]))
        else $error("read count not live");

    // write loads the reload value
    write_init_a: assert property (
        wr_sel[1] |=> st_r.init[1] == $past(pwdata[31:24]) &&
        st_r.cnt[1] == $past(pwdata[31:24]))
        else $error("write did not set count");

    // both qualifiers clear disable the address section
    addr_off_a: assert property (
        st_r.cfg[0][btte_pkg::F_WR_EN] == 1'b0 &&
        st_r.cfg[0][btte_pkg::F_RD_EN] == 1'b0 |-> !addr_hit[0])
        else $error("address match while disabled");

    // requester mismatch blocks the address section
    req_miss_a: assert property (
        st_r.cfg[0][btte_pkg::F_REQ_EN] &&
        abus.req_id != st_r.cfg[0][btte_pkg::F_REQ_LO +: 4] |-> !addr_hit[0])
        else $error("requester mismatch matched");

    // selected traps all missing blocks the address section
    trap_miss_a: assert property (
        st_r.cfg[0][3:0] != 4'h0 && (st_r.cfg[0][3:0] & abus.trap_hit) == 4'h0
        |-> !addr_hit[0])
        else $error("trap miss matched");

    // both id enables need both ids
    both_ids_a: assert property (
        st_r.cfg[0][6:5] == 2'b11 &&
        dbus.resp_id != st_r.cfg[0][btte_pkg::F_RESP_LO +: 4] |-> !data_hit[0])
        else $error("one id alone matched");

    // interrupt source fires only after a cycle with both mappers clear
    int_once_a: assert property (
        int_fire |-> !$past(int_any))
        else $error("interrupt refired without clearing");

    // debug line needs a high level between fires
    dbg_once_a: assert property (
        dbg_fire |=> !dbg_fire)
        else $error("debug line refired while low");

    // ready is a single-cycle answer
    rdy_pulse_a: assert property (
        pready |=> !pready)
        else $error("ready held too long");

    // no trap selects: any address passes the trap check
    trap_free_a: assert property (
        st_r.cfg[2][3:0] == 4'h0 && !st_r.cfg[2][btte_pkg::F_REQ_EN] &&
        st_r.cfg[2][btte_pkg::F_RD_EN] && rd_cls |-> addr_hit[2])
        else $error("unselected trap blocked match");

    // a hit in any selected trap is enough
    trap_take_a: assert property (
        (st_r.cfg[2][3:0] & abus.trap_hit) != 4'h0 && !st_r.cfg[2][btte_pkg::F_REQ_EN] &&
        st_r.cfg[2][btte_pkg::F_RD_EN] && rd_cls |-> addr_hit[2])
        else $error("selected trap hit ignored");

    // wrong data source blocks the data section
    dsrc_miss_a: assert property (
        st_r.cfg[3][btte_pkg::F_DSRC_EN] &&
        dbus.data_id != st_r.cfg[3][btte_pkg::F_DSRC_LO +: 4] |-> !data_hit[3])
        else $error("data source mismatch matched");

    // wrong responder blocks the data section
    resp_miss_a: assert property (
        st_r.cfg[3][btte_pkg::F_RESP_EN] &&
        dbus.resp_id != st_r.cfg[3][btte_pkg::F_RESP_LO +: 4] |-> !data_hit[3])
        else $error("responder mismatch matched");

    // write-class command passes the write qualifier
    wr_class_a: assert property (
        st_r.cfg[1][btte_pkg::F_WR_EN] && wr_cls && st_r.cfg[1][4:0] == 5'h00
        |-> addr_hit[1])
        else $error("write class not matched");

    // read-class command passes the read qualifier
    rd_class_a: assert property (
        st_r.cfg[1][btte_pkg::F_RD_EN] && rd_cls && st_r.cfg[1][4:0] == 5'h00
        |-> addr_hit[1])
        else $error("read class not matched");

    // an enabled mapper edge at zero count gives a pulse
    int_src_a: assert property (
        st_r.cfg[5][btte_pkg::F_INT_EN] && int_fire && !wr_sel[5] &&
        st_r.cnt[5] == 8'h00 |=> event_pulse[5])
        else $error("interrupt event missing");

    // an enabled line fall at zero count gives a pulse
    dbg_src_a: assert property (
        st_r.cfg[6][btte_pkg::F_DBG_EN] && dbg_fire && !wr_sel[6] &&
        st_r.cnt[6] == 8'h00 |=> event_pulse[6])
        else $error("debug line event missing");

    // count moves only on a condition or a write
    cnt_hold_a: assert property (
        !trig[4] && !wr_sel[4] |=> st_r.cnt[4] == $past(st_r.cnt[4]))
        else $error("count moved without cause");

    // an address match needs a live command on the bus
    addr_cmd_a: assert property (
        addr_hit[2] |-> abus.valid && (rd_cls || wr_cls))
        else $error("address match without command");

    // main scenarios
    addr_evt_c: cover property (addr_hit[0] && st_r.cnt[0] == 8'h00 ##1 event_pulse[0]);
    int_evt_c: cover property (int_fire && st_r.cfg[2][btte_pkg::F_INT_EN] ##1 event_pulse[2]);
    dbg_evt_c: cover property (dbg_fire && st_r.cfg[7][btte_pkg::F_DBG_EN] ##1 event_pulse[7]);
    count_c: cover property (trig[1] && st_r.cnt[1] == 8'h02 ##[1:20] event_pulse[1]);

endmodule : btte_trigger_events

/* verification/btte_far_side.sv */
// btte_far_side: bus agents, interrupt mappers and debug line facing the matchers
module btte_far_side (
    input wire logic pclk,
    output btte_pkg::btte_abus_s abus,
    output btte_pkg::btte_dbus_s dbus,
    output logic [1:0] int_trace,
    output logic dbg_line_n
);
    timeunit 1ns;
    timeprecision 1ps;
    // ************************************************************
    // far-side drivers, all launched on the rising edge
    // ************************************************************
    logic dbg_pull = 1'b0;  // someone pulls the open-drain line low
    // pull-up wins whenever nobody pulls
    assign dbg_line_n = dbg_pull ? 1'b0 : 1'b1;
    // quiet bus at time zero
    initial begin
        abus = '0;
        dbus = '0;
        int_trace = 2'h0;
    end
    // address phase for n cycles; a released bus keeps stale cmd and inverted ids
    task automatic addr(input btte_pkg::btte_cmd_e cmd, input logic [3:0] req,
                        input logic [3:0] trap, input int n);
        @(posedge pclk);
        abus <= '{valid: 1'b1, cmd: cmd, req_id: req, trap_hit: trap};
        repeat (n) @(posedge pclk);
        abus <= '{valid: 1'b0, cmd: cmd, req_id: ~req, trap_hit: ~trap};
    endtask : addr
    // one data beat; data id is the top nibble of the transaction id
    task automatic data(input logic [3:0] did, input logic [3:0] rid);
        @(posedge pclk);
        dbus <= '{valid: 1'b1, data_id: did, resp_id: rid};
        @(posedge pclk);
        dbus <= '{valid: 1'b0, data_id: ~did, resp_id: ~rid};
    endtask : data
    // mapper trace outputs as levels
    task automatic intr(input logic [1:0] v);
        @(posedge pclk);
        int_trace <= v;
    endtask : intr
    // pull or release the debug line
    task automatic dbg(input logic pull);
        @(posedge pclk);
        dbg_pull <= pull;
    endtask : dbg
endmodule : btte_far_side

/* verification/test_bus_trace_trigger_events.sv */
// test_bus_trace_trigger_events: apb and far-side driven checks of the eight matchers
module test_bus_trace_trigger_events;
    timeunit 1ns;
    timeprecision 1ps;
    // ************************************************************
    // clock, reset and design
    // ************************************************************
    logic pclk;
    logic presetn;  // held low for four cycles
    logic psel;
    logic penable;
    logic pwrite;
    logic [31:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    btte_pkg::btte_abus_s abus;
    btte_pkg::btte_dbus_s dbus;
    logic [1:0] int_trace;
    logic dbg_line_n;
    logic [7:0] event_pulse;
    int num_errors = 0;
    int cmp_count = 0;
    logic [31:0] rdat;  // read data taken at completion
    logic err;  // slave error taken at completion
    // 25 mhz clock
    initial begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end
    btte_trigger_events i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .abus(abus), .dbus(dbus),
        .int_trace(int_trace), .dbg_line_n(dbg_line_n), .event_pulse(event_pulse));
    btte_far_side i_far (.pclk(pclk), .abus(abus), .dbus(dbus), .int_trace(int_trace),
        .dbg_line_n(dbg_line_n));
    // ************************************************************
    // access and compare tasks
    // ************************************************************
    task automatic end_of_test();
        $display("errors %0d compares %0d", num_errors, cmp_count);
        if (num_errors == 0 && cmp_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : end_of_test
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        cmp_count++;
        if (got !== exp) begin
            num_errors++;
            $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : chk
    // one apb transfer; request held until pready is sampled high
    task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] d);
        int n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rdat = prdata;
        err = pslverr;
        if (n >= 20) chk(32'h1, 32'h0, "apb no answer");
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic wr(input int m, input logic [31:0] d);
        apb(1'b1, btte_pkg::TMC_OFF[m], d);
        chk(32'(err), 32'h0, "write error");
    endtask : wr
    task automatic rd(input int m, input logic [31:0] exp);
        apb(1'b0, btte_pkg::TMC_OFF[m], 32'h0);
        chk(rdat, exp, "readback");
        chk(32'(err), 32'h0, "read error");
    endtask : rd
    // counts pulses of matcher m over eight cycles; other matchers must stay quiet
    task automatic watch(input int m, input int exp);
        int c = 0;
        repeat (8) begin
            #1;
            if (event_pulse[m] === 1'b1) c++;
            chk(32'(event_pulse & ~(8'h1 << m)), 32'h0, "stray pulse");
            @(posedge pclk);
        end
        chk(32'(c), 32'(exp), "pulse count");
    endtask : watch
    // exclusive read on matcher 2 with given ids and trap hits
    task automatic acase(input logic [31:0] cfg, input logic [3:0] req,
                         input logic [3:0] trap, input int exp);
        wr(2, cfg);
        i_far.addr(btte_pkg::BTTE_CMD_EXCLUSIVE_READ, req, trap, 1);
        watch(2, exp);
    endtask : acase
    // one data beat on matcher 3
    task automatic dcase(input logic [31:0] cfg, input logic [3:0] did,
                         input logic [3:0] rid, input int exp);
        wr(3, cfg);
        i_far.data(did, rid);
        watch(3, exp);
    endtask : dcase
    // a hang counts as a mismatch; normal run is near 840 cycles
    initial begin
        #200000;
        num_errors++;
        end_of_test();
    end
    // ************************************************************
    // test sequence
    // ************************************************************
    initial begin
        presetn <= 1'b0;
        psel <= 1'b0;
        penable <= 1'b0;
        pwrite <= 1'b0;
        paddr <= 32'h0;
        pwdata <= 32'h0;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        for (int m = 0; m < 8; m++) begin
            rd(m, 32'h0);
            wr(m, 32'hffffffff);
            rd(m, 32'hfffffeff);
            wr(m, 32'h0);
        end
        apb(1'b0, btte_pkg::TMC_OFF_0 + 32'h4, 32'h0);
        chk(32'(err), 32'h1, "unmapped error");
        chk(rdat, 32'h0, "unmapped data");
        // every command against no, write, read and both qualifiers
        for (int qi = 0; qi < 4; qi++) begin
            for (int c = 0; c < 6; c++) begin
                wr(1, 32'(qi) << 10);
                i_far.addr(btte_pkg::btte_cmd_e'(c), 4'h0, 4'h0, 1);
                watch(1, ((qi[1] && c inside {1, 2}) || (qi[0] && c > 2)) ? 1 : 0);
            end
        end
        // matcher 1 would also see the reads below
        wr(1, 32'h0);
        acase(32'h00000800, 4'h7, 4'h0, 1);
        acase(32'h00000802, 4'h0, 4'h4, 0);
        acase(32'h00000802, 4'h0, 4'h2, 1);
        acase(32'h00005812, 4'h5, 4'h2, 1);
        acase(32'h00005812, 4'h4, 4'h2, 0);
        acase(32'h00005812, 4'h5, 4'h1, 0);
        dcase(32'h00300020, 4'h3, 4'h0, 1);
        dcase(32'h00300020, 4'h2, 4'h0, 0);
        dcase(32'h00090040, 4'h0, 4'h9, 1);
        dcase(32'h00090040, 4'h0, 4'h8, 0);
        dcase(32'h00390060, 4'h3, 4'h9, 1);
        dcase(32'h00390060, 4'h3, 4'h8, 0);
        dcase(32'h00390060, 4'h2, 4'h9, 0);
        dcase(32'h00390000, 4'h3, 4'h9, 0);
        // occurrence count: two skips then a pulse and a reload
        wr(4, 32'h02000800);
        rd(4, 32'h02000800);
        i_far.addr(btte_pkg::BTTE_CMD_SHARED_READ, 4'h0, 4'h0, 1);
        watch(4, 0);
        rd(4, 32'h01000800);
        i_far.addr(btte_pkg::BTTE_CMD_SHARED_READ, 4'h0, 4'h0, 2);
        watch(4, 1);
        rd(4, 32'h02000800);
        // mapper outputs on matcher 5
        wr(5, 32'h00000080);
        i_far.intr(2'h1);
        watch(5, 1);
        i_far.intr(2'h3);
        watch(5, 0);
        i_far.intr(2'h2);
        watch(5, 0);
        i_far.intr(2'h0);
        i_far.intr(2'h2);
        watch(5, 1);
        i_far.intr(2'h0);
        // debug line on matcher 6
        wr(6, 32'h00000200);
        i_far.dbg(1'b1);
        watch(6, 1);
        watch(6, 0);
        i_far.dbg(1'b0);
        watch(6, 0);
        i_far.dbg(1'b1);
        watch(6, 1);
        i_far.dbg(1'b0);
        // quiet matchers 5 and 6, they share the same sources
        wr(5, 32'h0);
        wr(6, 32'h0);
        // two sources sharing one count on matcher 7
        wr(7, 32'h01000280);
        i_far.intr(2'h1);
        watch(7, 0);
        i_far.dbg(1'b1);
        watch(7, 1);
        i_far.dbg(1'b0);
        i_far.intr(2'h0);
        watch(7, 0);
        // reset in mid-run clears a programmed matcher
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        rd(7, 32'h0);
        end_of_test();
    end
endmodule : test_bus_trace_trigger_events
